// *** bench/rcw_slow_src.sv ***
// ==========================================================
// free running source with a 70 ns period standing on the slow clock pin
module rcw_slow_src #(
    parameter int HALF_NS = 35
) (
    // slow clock pin
    output logic slow_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        slow_o = 1'b0;
        #3;
        forever begin
            #(HALF_NS) slow_o = ~slow_o;
        end
    end
endmodule

// *** bench/tb.sv ***
`include "rcw_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [2:0] strap = 3'h0;
    logic slow_pin;
    logic ext_sel = 1'b0;
    logic wd_en = 1'b0;
    logic kick = 1'b0;
    logic [31:0] int_lim = 32'h00000004;
    logic [31:0] rst_lim = 32'h00000008;
    logic stby = 1'b0;
    logic xtal_en, ext_en, pll_en, cfg_err, irq, wake, core_rst;
    logic [7:0] mult;
    logic [3:0] div;
    logic [2:0] src;
    logic irq_d = 1'b0;
    logic clr_cnt = 1'b0;
    int n_fail = 0, tests_run = 0, seed = 40;
    int n_irq = 0, n_wake = 0, n_rst = 0, i, k;
    always #5 sys_clk_i = ~sys_clk_i;
    rcw_slow_src slow_u (.slow_o(slow_pin));
    rcw_ref_clock_select #(.SLOW_DIV(2)) dut_u (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .freq_select_strap_i(strap), .slow_clock_in_i(slow_pin),
        .slow_ext_sel_i(ext_sel), .wd_enable_i(wd_en), .wd_kick_i(kick),
        .wd_int_limit_i(int_lim), .wd_rst_limit_i(rst_lim),
        .standby_i(stby), .xtal_en_o(xtal_en), .ext_clk_en_o(ext_en),
        .pll_mult_o(mult), .pll_div_o(div), .pll_en_o(pll_en),
        .cfg_err_o(cfg_err), .ref_src_o(src), .wd_irq_o(irq),
        .wd_wake_o(wake), .wd_core_rst_o(core_rst));
    // ==========================================================
    // event counters
    always @(posedge sys_clk_i) begin
        irq_d <= irq;
        if (clr_cnt) begin
            n_irq = 0;
            n_wake = 0;
            n_rst = 0;
        end else begin
            if (irq === 1'b1 && irq_d !== 1'b1) n_irq++;
            if (wake === 1'b1) n_wake++;
            if (core_rst === 1'b1) n_rst++;
        end
    end
    // ==========================================================
    // expectations
    function automatic logic [2:0] exp_src(input logic [2:0] c);
        if (c == 3'h0) return 3'h0;
        if (c[2]) return c - 3'h3;
        return 3'h5;
    endfunction
    function automatic logic [7:0] exp_mult(input logic [2:0] c);
        case (c)
            3'h0, 3'h4: return `RCW_MULT_19;
            3'h5: return `RCW_MULT_26;
            3'h6: return `RCW_MULT_38;
            3'h7: return `RCW_MULT_52;
            default: return 8'h00;
        endcase
    endfunction
    function automatic int ref_tenths(input logic [2:0] c);
        case (c)
            3'h5: return 260;
            3'h6: return 384;
            3'h7: return 520;
            default: return 192;
        endcase
    endfunction
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ==========================================================
    // reset with a strap code, then check the decoded selection
    task automatic strap_case(input logic [2:0] c);
        logic ok;
        ok = (c == 3'h0) || c[2];
        @(posedge sys_clk_i) rstn_i <= 1'b0;
        strap <= c;
        wd_en <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1;
        check("ref_src", src, exp_src(c));
        check("pll_mult", mult, exp_mult(c));
        check("pll_en", pll_en, ok);
        check("cfg_err", cfg_err, !ok);
        check("xtal_en", xtal_en, c == 3'h0);
        check("ext_en", ext_en, c[2]);
        check("pll_div", div, ok ? `RCW_DIV_19 : 4'h0);
        if (ok && div !== 4'h0)
            check("vco", ref_tenths(c) * mult / div, 24960);
        @(posedge sys_clk_i) strap <= ~c;
        repeat (4) @(posedge sys_clk_i);
        #1;
        check("held_src", src, exp_src(c));
    endtask
    task automatic clear_counts();
        clr_cnt <= 1'b1;
        @(posedge sys_clk_i) clr_cnt <= 1'b0;
        #1;
    endtask
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end
    initial begin
        for (i = 0; i < 8; i++) strap_case(i[2:0]);
        for (i = 0; i < 4; i++) strap_case(3'($random(seed)));
        // internal slow clock, standby: interrupt, wake, core reset
        strap_case(3'h4);
        @(posedge sys_clk_i) stby <= 1'b1;
        wd_en <= 1'b1;
        clear_counts();
        for (i = 0; i < 400 && n_rst == 0; i++) @(posedge sys_clk_i);
        #1;
        check("irq_seen", n_irq > 0, 1'b1);
        check("wake_seen", n_wake > 0, 1'b1);
        check("rst_seen", n_rst > 0, 1'b1);
        @(posedge sys_clk_i) kick <= 1'b1;
        @(posedge sys_clk_i) kick <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        check("irq_cleared", irq, 1'b0);
        // frequent kicks keep the watchdog quiet
        clear_counts();
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk_i) kick <= 1'b1;
            @(posedge sys_clk_i) kick <= 1'b0;
            repeat (4) @(posedge sys_clk_i);
        end
        #1;
        check("kicked_irq", n_irq, 0);
        check("kicked_wake", n_wake, 0);
        check("kicked_rst", n_rst, 0);
        // disabled watchdog raises nothing
        @(posedge sys_clk_i) wd_en <= 1'b0;
        clear_counts();
        repeat (300) @(posedge sys_clk_i);
        #1;
        check("off_events", n_irq + n_wake + n_rst, 0);
        // slow clock from the pin, random limits, not in standby
        for (k = 0; k < 3; k++) begin
            @(posedge sys_clk_i) ext_sel <= 1'b1;
            stby <= 1'b0;
            int_lim <= 2 + ($random(seed) & 5);
            rst_lim <= 10 + ($random(seed) & 3);
            @(posedge sys_clk_i) wd_en <= 1'b1;
            clear_counts();
            for (i = 0; i < 900 && n_rst == 0; i++) @(posedge sys_clk_i);
            #1;
            check("pin_irq", n_irq > 0, 1'b1);
            check("pin_rst", n_rst > 0, 1'b1);
            check("no_wake", n_wake, 0);
            @(posedge sys_clk_i) wd_en <= 1'b0;
            repeat (2) @(posedge sys_clk_i);
        end
        wrap_up();
    end
endmodule

// *** hw/rcw_map.svh ***
// Functional notes
// - crystal option accepts only a 19.2 MHz crystal
// - external reference must be 19.2, 26, 38.4 or 52 MHz
// - strap bit2 picks crystal or external; bits1:0 pick frequency
// - pll multiply factor follows the decoded reference frequency
// - core and interface rates never depend on the reference choice
// - watchdog can interrupt, wake from standby and reset the core
// - watchdog counts on a 32 kHz clock, optionally from a pin
// - firmware can disable the watchdog; then no events at all
`ifndef RCW_MAP_SVH
`define RCW_MAP_SVH
// ==========================================================
// strap codes
`define RCW_CODE_XTAL 3'h0
`define RCW_CODE_EXT19 3'h4
`define RCW_CODE_EXT26 3'h5
`define RCW_CODE_EXT38 3'h6
`define RCW_CODE_EXT52 3'h7
// ==========================================================
// pll settings: every reference lands on a 2496 MHz vco at divide 1
// 19.2*130 = 26*96 = 38.4*65 = 52*48 = 2496
`define RCW_MULT_19 8'h82
`define RCW_MULT_26 8'h60
`define RCW_MULT_38 8'h41
`define RCW_MULT_52 8'h30
`define RCW_DIV_19 4'h1
`define RCW_DIV_26 4'h1
`define RCW_DIV_38 4'h1
`define RCW_DIV_52 4'h1
// ==========================================================
// slow clock and watchdog
`define RCW_SYS_HZ 100000000
`define RCW_SLOW_HZ 32768
`define RCW_SLOW_DIV (`RCW_SYS_HZ / (2 * `RCW_SLOW_HZ))
`define RCW_WD_INT_DEF 32'h00008000
`define RCW_WD_RST_DEF 32'h00010000
`endif

// *** hw/rcw_pkg.sv ***
package rcw_pkg;
    typedef enum logic [2:0] {
        RCW_SRC_XTAL19,
        RCW_SRC_EXT19,
        RCW_SRC_EXT26,
        RCW_SRC_EXT38,
        RCW_SRC_EXT52,
        RCW_SRC_BAD
    } rcw_src_t;
    typedef enum logic [1:0] {
        RCW_WD_OFF,
        RCW_WD_RUN,
        RCW_WD_IRQ
    } rcw_wd_t;
endpackage

// *** hw/rcw_ref_clock_select.sv ***
`include "rcw_map.svh"
module rcw_ref_clock_select #(
    parameter int SLOW_DIV = `RCW_SLOW_DIV
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // straps and slow clock pin
    input wire logic [2:0] freq_select_strap_i,
    input wire logic slow_clock_in_i,
    input wire logic slow_ext_sel_i,
    // firmware watchdog control
    input wire logic wd_enable_i,
    input wire logic wd_kick_i,
    input wire logic [31:0] wd_int_limit_i,
    input wire logic [31:0] wd_rst_limit_i,
    input wire logic standby_i,
    // clock selection outputs
    output logic xtal_en_o,
    output logic ext_clk_en_o,
    output logic [7:0] pll_mult_o,
    output logic [3:0] pll_div_o,
    output logic pll_en_o,
    output logic cfg_err_o,
    output logic [2:0] ref_src_o,
    // watchdog outputs
    output logic wd_irq_o,
    output logic wd_wake_o,
    output logic wd_core_rst_o
);
    // ==========================================================
    // strap capture: three-stage sync runs through reset
    logic [2:0] strap_s0_r;
    logic [2:0] strap_s1_r;
    logic [2:0] strap_s2_r;
    logic [2:0] strap_r;
    logic seen_r;
    logic strap_ok_w;
    always_ff @(posedge sys_clk_i) begin
        strap_s0_r <= freq_select_strap_i;
        strap_s1_r <= strap_s0_r;
        strap_s2_r <= strap_s1_r;
    end
    assign strap_ok_w = (strap_s1_r == strap_s2_r);
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seen_r <= 1'b0;
        end else if (strap_ok_w) begin
            seen_r <= 1'b1;
        end
    end
    // first agreeing edge after release latches the strap
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_r <= 3'h0;
        end else if (!seen_r && strap_ok_w) begin
            strap_r <= strap_s2_r;
        end
    end
    // ==========================================================
    // decode
    function automatic rcw_pkg::rcw_src_t rcw_decode(input logic [2:0] c);
        unique case (c)
            `RCW_CODE_XTAL: return rcw_pkg::RCW_SRC_XTAL19;
            `RCW_CODE_EXT19: return rcw_pkg::RCW_SRC_EXT19;
            `RCW_CODE_EXT26: return rcw_pkg::RCW_SRC_EXT26;
            `RCW_CODE_EXT38: return rcw_pkg::RCW_SRC_EXT38;
            `RCW_CODE_EXT52: return rcw_pkg::RCW_SRC_EXT52;
            default: return rcw_pkg::RCW_SRC_BAD;
        endcase
    endfunction
    rcw_pkg::rcw_src_t src_w;
    logic bad_w;
    logic [7:0] mult_w;
    logic [3:0] div_w;
    assign src_w = rcw_decode(strap_r);
    assign bad_w = (src_w == rcw_pkg::RCW_SRC_BAD);
    // every factor lands on the same vco rate, so core rates stay fixed
    assign mult_w = (src_w == rcw_pkg::RCW_SRC_EXT26) ? `RCW_MULT_26 :
                    (src_w == rcw_pkg::RCW_SRC_EXT38) ? `RCW_MULT_38 :
                    (src_w == rcw_pkg::RCW_SRC_EXT52) ? `RCW_MULT_52 :
                    `RCW_MULT_19;
    assign div_w = (src_w == rcw_pkg::RCW_SRC_EXT26) ? `RCW_DIV_26 :
                   (src_w == rcw_pkg::RCW_SRC_EXT38) ? `RCW_DIV_38 :
                   (src_w == rcw_pkg::RCW_SRC_EXT52) ? `RCW_DIV_52 :
                   `RCW_DIV_19;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            xtal_en_o <= 1'b0;
            ext_clk_en_o <= 1'b0;
            pll_mult_o <= 8'h00;
            pll_div_o <= 4'h0;
            pll_en_o <= 1'b0;
            cfg_err_o <= 1'b0;
            ref_src_o <= 3'h0;
        end else if (seen_r) begin
            xtal_en_o <= (src_w == rcw_pkg::RCW_SRC_XTAL19);
            ext_clk_en_o <= !bad_w && strap_r[2];
            pll_mult_o <= bad_w ? 8'h00 : mult_w;
            pll_div_o <= bad_w ? 4'h0 : div_w;
            pll_en_o <= !bad_w;
            cfg_err_o <= bad_w;
            ref_src_o <= src_w;
        end
    end
    // ==========================================================
    // slow clock: 3-stage pin sync or internal divider
    logic [2:0] slow_sync_r;
    logic slow_lvl_r;
    logic slow_prev_r;
    logic int_slow_r;
    logic [15:0] div_cnt_r;
    logic slow_tick_w;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            slow_sync_r <= 3'h0;
            slow_lvl_r <= 1'b0;
        end else begin
            slow_sync_r <= {slow_sync_r[1:0], slow_clock_in_i};
            if (slow_sync_r[1] == slow_sync_r[2]) begin
                slow_lvl_r <= slow_sync_r[2];
            end
        end
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_cnt_r <= 16'h0000;
            int_slow_r <= 1'b0;
            slow_prev_r <= 1'b0;
        end else begin
            slow_prev_r <= slow_ext_sel_i ? slow_lvl_r : int_slow_r;
            if (div_cnt_r == 16'(SLOW_DIV - 1)) begin
                div_cnt_r <= 16'h0000;
                int_slow_r <= !int_slow_r;
            end else begin
                div_cnt_r <= div_cnt_r + 16'h0001;
            end
        end
    end
    assign slow_tick_w = (slow_ext_sel_i ? slow_lvl_r : int_slow_r)
                         && !slow_prev_r;
    // ==========================================================
    // watchdog
    rcw_pkg::rcw_wd_t wd_r;
    rcw_pkg::rcw_wd_t wd_nxt;
    logic [31:0] wd_cnt_r;
    logic int_hit_w;
    logic rst_hit_w;
    assign int_hit_w = slow_tick_w && (wd_cnt_r + 32'h1 >= wd_int_limit_i);
    assign rst_hit_w = slow_tick_w && (wd_cnt_r + 32'h1 >= wd_rst_limit_i);
    always_comb begin
        wd_nxt = wd_r;
        unique case (wd_r)
            rcw_pkg::RCW_WD_OFF: if (wd_enable_i) wd_nxt = rcw_pkg::RCW_WD_RUN;
            rcw_pkg::RCW_WD_RUN: begin
                if (!wd_enable_i) begin
                    wd_nxt = rcw_pkg::RCW_WD_OFF;
                end else if (!wd_kick_i && int_hit_w) begin
                    wd_nxt = rcw_pkg::RCW_WD_IRQ;
                end
            end
            rcw_pkg::RCW_WD_IRQ: begin
                if (!wd_enable_i) begin
                    wd_nxt = rcw_pkg::RCW_WD_OFF;
                end else if (wd_kick_i) begin
                    wd_nxt = rcw_pkg::RCW_WD_RUN;
                end
            end
            default: wd_nxt = rcw_pkg::RCW_WD_OFF;
        endcase
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wd_r <= rcw_pkg::RCW_WD_OFF;
            wd_cnt_r <= 32'h0;
            wd_irq_o <= 1'b0;
            wd_wake_o <= 1'b0;
            wd_core_rst_o <= 1'b0;
        end else begin
            wd_r <= wd_nxt;
            if (!wd_enable_i || wd_kick_i || rst_hit_w) begin
                wd_cnt_r <= 32'h0;
            end else if (slow_tick_w) begin
                wd_cnt_r <= wd_cnt_r + 32'h1;
            end
            wd_irq_o <= wd_enable_i
                && (wd_nxt == rcw_pkg::RCW_WD_IRQ);
            wd_wake_o <= wd_enable_i && standby_i && int_hit_w && !wd_kick_i;
            wd_core_rst_o <= wd_enable_i && !wd_kick_i
                && rst_hit_w;
        end
    end
    // ==========================================================
    // checks
    sequence s_irq_due;
        wd_r == rcw_pkg::RCW_WD_RUN && wd_enable_i && !wd_kick_i
            && int_hit_w;
    endsequence
    sequence s_wake_due;
        wd_enable_i && standby_i && !wd_kick_i && int_hit_w;
    endsequence
    sequence s_rst_due;
        wd_enable_i && !wd_kick_i && rst_hit_w;
    endsequence
    a_strap_held: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i) seen_r && $past(seen_r) |-> $stable(strap_r))
        else $error("strap changed after capture");
    a_bad_no_pll: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i) cfg_err_o |-> !pll_en_o && pll_mult_o == 8'h00)
        else $error("pll enabled on bad strap");
    a_xtal_only_19: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        xtal_en_o |-> pll_mult_o == `RCW_MULT_19 && !ext_clk_en_o)
        else $error("crystal with wrong factor");
    a_mult_52: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        $past(seen_r) && strap_r == `RCW_CODE_EXT52
        |-> pll_mult_o == `RCW_MULT_52)
        else $error("wrong factor for 52");
    a_ext_decode: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        $past(seen_r) && strap_r[2] |-> ext_clk_en_o && pll_en_o)
        else $error("external code not decoded");
    a_bad_code: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        $past(seen_r) && !strap_r[2] && strap_r[1:0] != 2'h0 |-> cfg_err_o)
        else $error("bad code not flagged");
    a_vco_same: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i) pll_en_o |-> pll_div_o == 4'h1)
        else $error("divider moved with reference");
    a_off_quiet: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        !wd_enable_i |=> !wd_irq_o && !wd_wake_o && !wd_core_rst_o)
        else $error("watchdog event while disabled");
    a_rst_pulse: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i) s_rst_due |=> wd_core_rst_o)
        else $error("core reset missed");
    a_count_tick: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        !slow_tick_w && !wd_kick_i && wd_enable_i && $past(wd_enable_i)
        |=> $stable(wd_cnt_r))
        else $error("watchdog counted without slow tick");
    a_irq_raise: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i) s_irq_due |=> wd_irq_o)
        else $error("interrupt missed");
    a_wake_pulse: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i) s_wake_due |=> wd_wake_o)
        else $error("standby wake missed");
    a_kick_quiet: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        wd_kick_i |=> !wd_irq_o && !wd_wake_o && !wd_core_rst_o)
        else $error("watchdog event on kick");
endmodule
